// File: bench/pmc_cpu_model.sv
// CPU core model: issues power-save instructions and interrupts.
`timescale 1ns/1ns
`default_nettype none
module pmc_cpu_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic go,           // Execute one power-save instruction
  input wire logic op,           // Operand for it
  input wire logic [7:0] dly,    // Interrupt delay, FF for none
  input wire logic irq_hold,     // Extra interrupt from the bench
  input wire logic pwrsave_done,
  output logic pwrsave_req,
  output logic pwrsave_op,
  output logic irq_pending
);
  logic [7:0] cnt;  // Cycles until the interrupt
  logic arm;        // Interrupt scheduled
  logic irq_q;      // Interrupt held until wake
  assign irq_pending = irq_q | irq_hold;
  // One-cycle instruction, held interrupt until the core wakes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pwrsave_req <= 1'b0;
      pwrsave_op <= 1'b0;
      arm <= 1'b0;
      irq_q <= 1'b0;
      cnt <= 8'h00;
    end else begin
      pwrsave_req <= go;
      if (go) begin
        pwrsave_op <= op;
        cnt <= dly;
        arm <= (dly != 8'hFF) && (dly != 8'h00);
        irq_q <= (dly == 8'h00);  // Coincident with the instruction
      end else if (arm && cnt <= 8'h01) begin
        irq_q <= 1'b1;
        arm <= 1'b0;
      end else if (cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
      end
      if (pwrsave_done) irq_q <= 1'b0;  // Handler clears the source
    end
  end
endmodule
`default_nettype wire

// File: bench/pmc_props.sv
// Port-level checker for the power-mode controller.
`timescale 1ns/1ns
`default_nettype none
module pmc_props
  import pmc_pkg::*;
#(
  parameter int RATIO_BITS = 3  // Mirrors the design parameter
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pwrsave_req,
  input wire logic pwrsave_op,
  input wire logic irq_pending,
  input wire logic low_power_rc_osc_requested,
  input wire pmc_clk_ctrl_t clk_ctrl,
  input wire logic pwrsave_done,
  input wire logic [2:0] osc_select
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------
  // Helper: a power sequence is under way
  // ----------------------------------------------
  logic busy;  // Set on an accepted request
  wire take = pwrsave_req && !busy;  // Request taken in run
  always_ff @(posedge clk) begin
    if (!rst_n) busy <= 1'b0;
    else if (pwrsave_done) busy <= 1'b0;
    else if (pwrsave_req) busy <= 1'b1;
  end
  // CPU gated in entry and low state
  sequence s_gated;
    ##1 (!clk_ctrl.cpu_clk_en && !pwrsave_done) ##1 !clk_ctrl.cpu_clk_en;
  endsequence
  property p_clr_cause;
    clk_ctrl.wdt_clear |-> $past(take);
  endproperty
  property p_idle_clr;
    take && pwrsave_op == PMC_OP_IDLE |=> clk_ctrl.wdt_clear;
  endproperty
  property p_sleep_low;
    take && pwrsave_op == PMC_OP_SLEEP |-> s_gated ##0
      (clk_ctrl.pin_freeze && !clk_ctrl.sys_osc_on);
  endproperty
  property p_idle_low;
    take && pwrsave_op == PMC_OP_IDLE |-> ##2 (clk_ctrl.sys_osc_on &&
      clk_ctrl.periph_clk_en && !clk_ctrl.cpu_clk_en && !clk_ctrl.pin_freeze);
  endproperty
  property p_frozen;
    clk_ctrl.pin_freeze |-> !clk_ctrl.sys_osc_on && !clk_ctrl.periph_clk_en &&
      !clk_ctrl.fcm_active;
  endproperty
  property p_low_power_rc_osc;
    clk_ctrl.pin_freeze && low_power_rc_osc_requested |-> clk_ctrl.low_power_rc_osc_on;
  endproperty
  property p_defer;
    take && irq_pending |-> s_gated;
  endproperty
  property p_irq_wake;
    busy && irq_pending && !pwrsave_done |-> ##[1:4] pwrsave_done;
  endproperty
  property p_resume;
    pwrsave_done |=> clk_ctrl.sys_osc_on && clk_ctrl.periph_clk_en && !clk_ctrl.pin_freeze;
  endproperty
  property p_osc_hold;
    busy |-> osc_select == $past(osc_select);
  endproperty
  a_clr_cause: assert property (p_clr_cause) else $error("watchdog clear without entry");
  a_idle_clr: assert property (p_idle_clr) else $error("idle entry missed clear");
  a_sleep_low: assert property (p_sleep_low) else $error("sleep state wrong");
  a_idle_low: assert property (p_idle_low) else $error("idle state wrong");
  a_frozen: assert property (p_frozen) else $error("freeze with clocks on");
  a_low_power_rc_osc: assert property (p_low_power_rc_osc) else $error("rc oscillator off in sleep");
  a_defer: assert property (p_defer) else $error("entry not completed");
  a_irq_wake: assert property (p_irq_wake) else $error("no wake on interrupt");
  a_resume: assert property (p_resume) else $error("clocks not restored");
  a_osc_hold: assert property (p_osc_hold) else $error("oscillator changed");
endmodule
bind pmc_power_mode_controller pmc_props #(.RATIO_BITS(RATIO_BITS)) u_props (
  .clk(clk), .rst_n(rst_n), .pwrsave_req(pwrsave_req), .pwrsave_op(pwrsave_op),
  .irq_pending(irq_pending), .low_power_rc_osc_requested(low_power_rc_osc_requested), .clk_ctrl(clk_ctrl),
  .pwrsave_done(pwrsave_done), .osc_select(osc_select));
`default_nettype wire

// File: bench/tb_top.sv
// Self-checking bench for the power-mode controller.
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import pmc_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata_q;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  logic go = 1'b0, op = 1'b0, irq_hold = 1'b0, wdt = 1'b0, low_power_rc_osc = 1'b0, pin = 1'b1;
  logic [7:0] dly = 8'hFF;
  logic wdt_on = 1'b0;  // Bench copy of the watchdog enable
  wire req, rop, irq, done, sink;
  wire [2:0] osc;
  pmc_clk_ctrl_t cc;
  logic [1:0] r;
  logic [31:0] rng = 32'h66407649;  // Fixed seed
  int num_errors = 0, checks_done = 0, cyc = 0, c, p, e;
  pmc_power_mode_controller uut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pwrsave_req(req), .pwrsave_op(rop), .irq_pending(irq),
    .wdt_timeout(wdt), .low_power_rc_osc_requested(low_power_rc_osc), .wake_sense_pin(pin), .clk_ctrl(cc),
    .pwrsave_done(done), .waker_sink_on(sink), .osc_select(osc));
  pmc_cpu_model cpu (.clk(clk), .rst_n(rst_n), .go(go), .op(op), .dly(dly),
    .irq_hold(irq_hold), .pwrsave_done(done), .pwrsave_req(req), .pwrsave_op(rop),
    .irq_pending(irq));
  // -------------------------------------
  // Clock, timeout, helpers
  // -------------------------------------
  initial forever #20 clk = ~clk;
  // Hang guard, well past the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Entry clears the watchdog on idle, and on sleep only when it is enabled
  function automatic logic exp_clr(input logic o, input logic en);
    return (o == PMC_OP_IDLE) || en;
  endfunction
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Bus write: address and data released separately when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic fin;
    fin = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!fin) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        fin = 1'b1;
      end
    end
    @(posedge clk);  // An edge passes before the next request
  endtask
  task automatic rd(input logic [7:0] a);
    logic fin;
    fin = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!fin) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        r = rresp;
        rdata_q = rdata;
        rready <= 1'b0;
        fin = 1'b1;
      end
    end
    @(posedge clk);  // An edge passes before the next request
  endtask
  // Power-save instruction; wake source 0 irq, 1 watchdog, 2 pin
  task automatic pw(input logic o, input logic [7:0] d, input logic [1:0] src);
    int n;
    int w;
    n = 0;
    w = 0;
    go <= 1'b1;
    op <= o;
    dly <= d;
    @(posedge clk);
    go <= 1'b0;
    while (!done && n < 64) begin
      @(posedge clk);
      n++;
      w += int'(cc.wdt_clear);
      wdt <= (src == 2'd1) && (n == 6);
      if (src == 2'd2 && n == 6) pin <= 1'b0;  // Capacitor discharged
    end
    @(posedge clk);
    wdt <= 1'b0;
    chk("wake", 32'(n < 64), 32'h1);
    chk("watchdog clear", 32'(w), 32'(exp_clr(o, wdt_on)));
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // -------------------------------------
  // Main sequence
  // -------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(PMC_OFF_WAKE_CTRL);
    chk("wake_ctrl reset", rdata_q, 32'h0);
    rd(PMC_OFF_CLOCK_DIVIDER_REG);
    chk("clock_divider_reg reset", rdata_q, 32'h0);
    wr(PMC_OFF_WAKE_CTRL, 32'h0000FFFF);
    rd(PMC_OFF_WAKE_CTRL);
    chk("wake_ctrl fields", rdata_q, 32'h0000A100);
    wr(8'h40, 32'h1);
    chk("bresp unmapped", 32'(r), 32'h2);
    rd(8'h40);
    chk("rresp unmapped", {rdata_q[29:0], r}, 32'h3);
    // Doze ratios: CPU gets one cycle in two to the n
    for (int n = 0; n < 8; n++) begin
      wr(PMC_OFF_CLOCK_DIVIDER_REG, 32'h00000800 | (n << 12));
      c = 0;
      p = 0;
      repeat (256) begin
        @(posedge clk);
        c += int'(cc.cpu_clk_en);
        p += int'(cc.periph_clk_en);
      end
      e = 256 >> n;
      chk("cpu pulses", 32'(c + 1 >= e && c <= e + 1), 32'h1);
      chk("periph pulses", 32'(p), 32'd256);
    end
    // Recover-on-interrupt off then on
    for (int k = 0; k < 2; k++) begin
      wr(PMC_OFF_CLOCK_DIVIDER_REG, k ? 32'h00008800 : 32'h00000800);
      irq_hold <= 1'b1;
      repeat (3) @(posedge clk);
      irq_hold <= 1'b0;
      rd(PMC_OFF_CLOCK_DIVIDER_REG);
      chk("doze after irq", rdata_q, k ? 32'h00008000 : 32'h00000800);
    end
    wr(PMC_OFF_CLOCK_DIVIDER_REG, 32'h0);
    // Pin waker: charge, release, enable with sink, sleep
    pin <= 1'b1;
    wr(PMC_OFF_WAKE_CTRL, 32'h00008100);
    chk("sink on", 32'(sink), 32'h1);
    pw(PMC_OP_SLEEP, 8'hFF, 2'd2);
    rd(PMC_OFF_IFLAG5);
    chk("waker flag", rdata_q, 32'h1);
    wr(PMC_OFF_IFLAG5, 32'h0);
    wr(PMC_OFF_WAKE_CTRL, 32'h0);
    pin <= 1'b1;
    wr(PMC_OFF_CONFIG, 32'h3);
    wdt_on = 1'b1;
    wr(PMC_OFF_OSC, 32'h5);
    pw(PMC_OP_SLEEP, 8'h00, 2'd0);
    rd(PMC_OFF_OSC);
    chk("osc after wake", rdata_q, 32'h5);
    chk("osc in use", 32'(osc), 32'h5);
    // Random instructions, delays and wake sources
    repeat (12) begin
      rng = lfsr(rng);
      low_power_rc_osc <= rng[7];
      pw(rng[0], rng[1] ? 8'hFF : {5'h0, rng[4:2]}, {1'b0, rng[1]});
    end
    report_and_stop();
  end
endmodule
`default_nettype wire

// File: hw/pmc_pkg.sv
// Package for the power-mode controller: register map, fields, states.
package pmc_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets (chosen)
  // ----------------------------------------------------------------
  localparam logic [7:0] PMC_OFF_WAKE_CTRL = 8'h00;  // low_power_wake_control
  localparam logic [7:0] PMC_OFF_CLOCK_DIVIDER_REG = 8'h04;     // clock_divider_reg
  localparam logic [7:0] PMC_OFF_IFLAG5 = 8'h08;     // interrupt_flag_reg_five
  localparam logic [7:0] PMC_OFF_STATUS = 8'h0C;     // mode and clock status
  localparam logic [7:0] PMC_OFF_CONFIG = 8'h10;     // watchdog/monitor enables
  localparam logic [7:0] PMC_OFF_OSC = 8'h14;        // oscillator select

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PMC_WC_ENABLE_BIT = 15;       // waker_module_enable
  localparam int PMC_WC_STOP_IDLE_BIT = 13;    // waker_stop_in_idle
  localparam int PMC_WC_SINK_BIT = 8;          // waker_current_sink_enable
  localparam int PMC_CD_ROI_BIT = 15;          // recover_on_interrupt
  localparam int PMC_CD_RATIO_LSB = 12;        // slowdown ratio [14:12]
  localparam int PMC_CD_DOZE_BIT = 11;         // cpu_slowdown_enable
  localparam int PMC_IF5_WAKER_BIT = 0;        // waker_event_flag
  localparam int PMC_CFG_WDT_EN_BIT = 0;       // watchdog enabled
  localparam int PMC_CFG_FCM_EN_BIT = 1;       // clock fail monitor enabled

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] PMC_RST_WAKE_CTRL = 16'h0000;
  localparam logic [15:0] PMC_RST_CLOCK_DIVIDER_REG = 16'h0000;   // ratio 1:1
  localparam logic [1:0] PMC_RST_CONFIG = 2'h0;
  localparam logic [2:0] PMC_RST_OSC = 3'h0;

  // Power-save instruction operand encodings
  localparam logic PMC_OP_SLEEP = 1'b0;
  localparam logic PMC_OP_IDLE = 1'b1;

  // Power modes, Gray coded along run -> entering -> low power -> wake
  typedef enum logic [1:0] {
    PMC_RUN = 2'b00,
    PMC_ENTER = 2'b01,
    PMC_LOW = 2'b11,
    PMC_WAKE = 2'b10
  } pmc_state_t;

  // Clock and freeze controls towards the rest of the chip
  typedef struct packed {
    logic sys_osc_on;      // system clock source running
    logic cpu_clk_en;      // CPU clock gate (includes doze pulses)
    logic periph_clk_en;   // system-clocked peripherals
    logic low_power_rc_osc_on;         // low_power_rc_osc running
    logic fcm_active;      // clock_fail_monitor may run
    logic pin_freeze;      // hold I/O directions and latches
    logic wdt_clear;       // one-cycle watchdog clear
  } pmc_clk_ctrl_t;

endpackage

// File: hw/pmc_power_mode_controller.sv
// Power-mode controller: sleep/idle sequencing, pin waker and doze divider.
`timescale 1ns/1ns
`default_nettype none
module pmc_power_mode_controller
  import pmc_pkg::*;
#(
  parameter int RATIO_BITS = 3  // width of the slowdown ratio field
) (
  input wire logic clk,
  input wire logic rst_n,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // CPU side
  input wire logic pwrsave_req,
  input wire logic pwrsave_op,
  input wire logic irq_pending,
  input wire logic wdt_timeout,
  input wire logic low_power_rc_osc_requested,
  input wire logic wake_sense_pin,
  // Outputs
  output pmc_clk_ctrl_t clk_ctrl,
  output logic pwrsave_done,
  output logic waker_sink_on,
  output logic [2:0] osc_select
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  // The ratio field is fixed at three bits in the divider register;
  // any other width would misplace the fields above it
  if (RATIO_BITS != 3) begin : g_bad_ratio
    $error("RATIO_BITS must be 3");
  end

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  // Stage one may be metastable and feeds nothing but stage two
  logic pin_meta;   // First stage, read only by pin_sync
  logic pin_sync;   // Safe pin level

  // Pin is asynchronous to clk, two flops before use
  // Both stages reset high: a charged capacitor reads high, so a reset
  // never looks like a discharge and cannot trip the waker
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
    end else begin
      pin_meta <= wake_sense_pin;
      pin_sync <= pin_meta;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Software-visible control bits; each holds its value across sleep except waker_event_flag, which a waker trip sets
  logic wc_enable;      // waker_module_enable
  logic wc_stop_idle;   // waker_stop_in_idle
  logic wc_sink;        // waker_current_sink_enable
  logic cd_roi;         // recover_on_interrupt
  logic [2:0] cd_ratio; // slowdown ratio
  logic cd_doze;        // cpu_slowdown_enable
  logic waker_event_flag;
  logic cfg_wdt_en;     // watchdog enabled
  logic cfg_fcm_en;     // clock fail monitor enabled
  logic [2:0] osc_sel;  // next_osc_select
  // Sequencer state and what was latched when the instruction was taken
  logic [2:0] osc_at_entry;
  pmc_state_t state;
  logic sleep_mode;     // Latched operand of the instruction

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  // Held halves of a write, each captured on its own handshake
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  // Commit only when both halves are held and no response is still waiting,
  // so a slow bready can never lose a second write
  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire wr_wc = do_write && (aw_addr == PMC_OFF_WAKE_CTRL);
  wire wr_cd = do_write && (aw_addr == PMC_OFF_CLOCK_DIVIDER_REG);
  wire wr_if5 = do_write && (aw_addr == PMC_OFF_IFLAG5);
  wire wr_cfg = do_write && (aw_addr == PMC_OFF_CONFIG);
  wire wr_osc = do_write && (aw_addr == PMC_OFF_OSC);
  wire wr_known = wr_wc || wr_cd || wr_if5 || wr_cfg || wr_osc ||
                  (do_write && aw_addr == PMC_OFF_STATUS);

  // Each channel takes one item, then refuses until the commit
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;

  // Accept address and data in either order, answer when both held
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      // Capture the word address; byte bits are ignored
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
      end
      // Capture data and lane strobes
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      // Both halves held: release them and answer
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? 2'h0 : 2'h2;  // SLVERR when unmapped
      end else if (s_axi_bready) begin
        // Response taken by the master
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Power mode sequencer
  // ----------------------------------------------------------------
  logic wake_evt;        // Any wake source
  logic waker_trip;      // Pin discharged below threshold in sleep
  wire in_sleep = (state == PMC_LOW) && sleep_mode;
  wire in_idle = (state == PMC_LOW) && !sleep_mode;
  wire waker_active = wc_enable && !(in_idle && wc_stop_idle);

  // The waker only trips in sleep: in idle or run the pin is ignored, and
  // the stop-in-idle bit only gates the sink
  assign waker_trip = in_sleep && waker_active && wc_sink && !pin_sync;
  // Wake sources are ignored in ENTER and act once LOW is reached if still pending
  assign wake_evt = irq_pending || wdt_timeout || waker_trip;

  // Sequence run -> enter -> low -> wake -> run
  // Entry always takes one full cycle, so an interrupt that arrives with the
  // instruction is only acted on once the low state is reached
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // Any reset wakes the device
      state <= PMC_RUN;
      sleep_mode <= 1'b0;
      osc_at_entry <= PMC_RST_OSC;
    end else begin
      unique case (state)
        PMC_RUN: begin
          // Instructions outside run are ignored
          if (pwrsave_req) begin
            // Remember the mode and the oscillator in use
            state <= PMC_ENTER;
            sleep_mode <= (pwrsave_op == PMC_OP_SLEEP);
            osc_at_entry <= osc_sel;
          end
        end
        // CPU clock gated and watchdog cleared (idle always, sleep only if enabled) during this one cycle
        PMC_ENTER: begin
          state <= PMC_LOW;
        end
        PMC_LOW: begin
          // Stay low until a wake source fires
          if (wake_evt) begin
            state <= PMC_WAKE;
          end
        end
        // One cycle of done; the core runs on from the next
        PMC_WAKE: begin
          state <= PMC_RUN;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Waker flag and software registers
  // ----------------------------------------------------------------
  // Flag set wins over a software clear in the same cycle
  // so a wake that lands with the clear is never lost
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      waker_event_flag <= 1'b0;
    end else if (waker_trip && wake_evt) begin
      waker_event_flag <= 1'b1;
    end else if (wr_if5 && w_strb[0]) begin
      // Software clears it after reading the wake source
      waker_event_flag <= w_data[PMC_IF5_WAKER_BIT];
    end
  end

  // Control registers, byte-lane writes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wc_enable <= PMC_RST_WAKE_CTRL[PMC_WC_ENABLE_BIT];
      wc_stop_idle <= PMC_RST_WAKE_CTRL[PMC_WC_STOP_IDLE_BIT];
      wc_sink <= PMC_RST_WAKE_CTRL[PMC_WC_SINK_BIT];
      cd_roi <= PMC_RST_CLOCK_DIVIDER_REG[PMC_CD_ROI_BIT];
      cd_ratio <= PMC_RST_CLOCK_DIVIDER_REG[PMC_CD_RATIO_LSB +: 3];
      cd_doze <= PMC_RST_CLOCK_DIVIDER_REG[PMC_CD_DOZE_BIT];
      {cfg_fcm_en, cfg_wdt_en} <= PMC_RST_CONFIG;
      osc_sel <= PMC_RST_OSC;
    end else begin
      // All wake control fields sit in the upper byte lane
      if (wr_wc && w_strb[1]) begin
        wc_enable <= w_data[PMC_WC_ENABLE_BIT];
        wc_stop_idle <= w_data[PMC_WC_STOP_IDLE_BIT];
        wc_sink <= w_data[PMC_WC_SINK_BIT];
      end
      if (wr_cd && w_strb[1]) begin
        cd_roi <= w_data[PMC_CD_ROI_BIT];
        cd_ratio <= w_data[PMC_CD_RATIO_LSB +: 3];
        cd_doze <= w_data[PMC_CD_DOZE_BIT];
      end else if (cd_roi && cd_doze && irq_pending && state == PMC_RUN) begin
        // A software write in the same cycle takes priority
        cd_doze <= 1'b0;
      end
      // Watchdog and monitor enables, for clears and oscillator keep-alive
      if (wr_cfg && w_strb[0]) begin
        cfg_wdt_en <= w_data[PMC_CFG_WDT_EN_BIT];
        cfg_fcm_en <= w_data[PMC_CFG_FCM_EN_BIT];
      end
      // Oscillator select changes only while running
      // so the source latched at entry stays the one restored on wake
      if (wr_osc && w_strb[0] && state == PMC_RUN) begin
        osc_sel <= w_data[2:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Doze divider
  // ----------------------------------------------------------------
  // Seven bits cover the longest ratio of 128 clocks
  logic [6:0] doze_cnt;  // Counts peripheral clocks per CPU clock
  wire [6:0] doze_last = 7'((8'h01 << cd_ratio) - 8'h01);
  wire doze_tick = !cd_doze || (doze_cnt >= doze_last);

  // Free counter on clk keeps both domains phase aligned
  // Ticks on reaching the last count or beyond, so a ratio lowered in
  // mid-count takes effect at once instead of running on to the wrap
  always_ff @(posedge clk) begin
    if (!rst_n || !cd_doze || doze_tick) begin
      doze_cnt <= 7'h00;
    end else begin
      // Count clocks until the CPU gets its next pulse
      doze_cnt <= doze_cnt + 7'h01;
    end
  end

  // ----------------------------------------------------------------
  // Clock and freeze controls
  // ----------------------------------------------------------------
  // Controls are decoded straight from the state, so they change on the
  // same edge as the mode and need no extra pipeline stage
  wire low = (state == PMC_LOW);
  wire entering = (state == PMC_ENTER);
  assign clk_ctrl.sys_osc_on = !in_sleep;
  assign clk_ctrl.cpu_clk_en = !low && !entering && doze_tick;
  assign clk_ctrl.periph_clk_en = !in_sleep;
  assign clk_ctrl.fcm_active = cfg_fcm_en && !in_sleep;
  // RC kept alive in sleep only on request; otherwise also for watchdog or monitor
  assign clk_ctrl.low_power_rc_osc_on = in_sleep ? low_power_rc_osc_requested :
                            (cfg_wdt_en || cfg_fcm_en || low_power_rc_osc_requested);
  assign clk_ctrl.pin_freeze = in_sleep;
  // Clear in the entry cycle: sleep only if enabled, idle always
  assign clk_ctrl.wdt_clear = entering && (!sleep_mode || cfg_wdt_en);
  // Done flags the wake cycle to the core
  assign pwrsave_done = (state == PMC_WAKE);
  assign waker_sink_on = waker_active && wc_sink;
  // Outside run the core sees the oscillator latched at entry
  assign osc_select = (state == PMC_RUN) ? osc_sel : osc_at_entry;

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  // Word-aligned read address; unused fields read as zero
  wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
  wire [15:0] rd_wc = {wc_enable, 1'b0, wc_stop_idle, 4'h0, wc_sink, 8'h00};
  wire [15:0] rd_cd = {cd_roi, cd_ratio, cd_doze, 11'h000};
  wire [15:0] rd_st = {11'h000, sleep_mode, state, clk_ctrl.cpu_clk_en, pin_sync};
  logic [31:0] rd_mux;
  logic rd_hit;

  // Unmapped reads return zero with DECERR
  // Reads have no side effects, so a repeated read is always safe
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (ra)
      PMC_OFF_WAKE_CTRL: rd_mux = {16'h0000, rd_wc};
      PMC_OFF_CLOCK_DIVIDER_REG: rd_mux = {16'h0000, rd_cd};
      PMC_OFF_IFLAG5: rd_mux = {31'h0, waker_event_flag};
      PMC_OFF_STATUS: rd_mux = {16'h0000, rd_st};
      PMC_OFF_CONFIG: rd_mux = {30'h0, cfg_fcm_en, cfg_wdt_en};
      PMC_OFF_OSC: rd_mux = {29'h0, osc_sel};
      default: rd_hit = 1'b0;
    endcase
  end

  // A new address is taken only once the previous data has been accepted
  assign s_axi_arready = !s_axi_rvalid;

  // One read in flight, data registered
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      // Capture data for the address just taken
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_hit ? 2'h0 : 2'h3;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire
